/* File: shared/wake_fault_defs.svh */
`ifndef WAKE_FAULT_DEFS_SVH
`define WAKE_FAULT_DEFS_SVH
// timings in ns and derived cycle counts at 40 MHz (25 ns period)
`define CLK_PERIOD_NS 25
`define INIT_TIME_NS 1000
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OC_CONFIRM_NS 2000
`define OC_CONFIRM_CYCLES ((`OC_CONFIRM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RETRY_WAIT_NS 4000000
`define RETRY_WAIT_CYCLES ((`RETRY_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAULT_CLEAR_NS 2000000
`define FAULT_CLEAR_CYCLES ((`FAULT_CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_MIN_NS 1000
`define PULSE_MIN_CYCLES ((`PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_MAX_NS 40000
`define PULSE_MAX_CYCLES (`PULSE_MAX_NS / `CLK_PERIOD_NS)
`define CNT_W 24
`endif

/* File: shared/wake_fault_pkg.sv */
`include "wake_fault_defs.svh"
package wake_fault_pkg;
   typedef enum logic [1:0] {VAR_HW, VAR_SPI_INT, VAR_SPI_EXT} variant_e;
   typedef enum {ST_SLEEP, ST_INIT_ACK, ST_STANDBY, ST_FAULT_OFF, ST_RETRY_ON, ST_CLEARING}
      state_e;
   typedef logic [`CNT_W-1:0] count_t;
endpackage

/* File: core/wake_handshake_fault_reaction.sv */
`timescale 1ns/100ps
`include "wake_fault_defs.svh"
// Contract
// (R1) controller drives sleep request high to start wake-up
// (R2) after leaving sleep, device pulls fault indicator low as wake acknowledge
// (R3) internal-regulator variants hold reset during regulator undervoltage, then acknowledge
// (R4) external-supply variant drives reset from that supply undervoltage
// (R5) hardwired: controller acknowledges with sleep reset pulse after indicator low
// (R6) SPI: controller acknowledges with clear-fault command after indicator low
// (R7) on acknowledge, release fault indicator and enter standby
// (R8) confirmed overcurrent disables output and pulls indicator low
// (R9) retry: re-enable after wait, disable again on fault, indicator stays low
// (R10) thermal retry waits for cooling, not the fixed wait
// (R11) fault-free retry keeps output on, indicator released after clear time
// (R12) SPI: fault status latched until clear-fault command
// (R13) latch: output off until clear command or reset pulse, then re-enabled
// (R14) overcurrent still present after latch clear trips again
// (R15) high-side short to ground shows on sense output while disabled; code shows it only in ST_FAULT_OFF after an overcurrent shutdown
// (R16) SPI variants provide 4-wire daisy-chain interface (outside this block)
// (R17) SPI variants detect frame errors and lock bits (outside this block)
// (R18) external-supply variant has no sleep request input
// (R19) without sleep input, sleep request treated as permanently high
// (R20) reset pulse is a short low on sleep input within parameter widths
module wake_handshake_fault_reaction
   import wake_fault_pkg::*;
#(
   parameter variant_e VARIANT = VAR_HW,
   parameter int RETRY_WAIT = `RETRY_WAIT_CYCLES,
   parameter int FAULT_CLEAR = `FAULT_CLEAR_CYCLES,
   parameter int OC_CONFIRM = `OC_CONFIRM_CYCLES,
   parameter int INIT_TIME = `INIT_CYCLES,
   parameter int PULSE_MIN = `PULSE_MIN_CYCLES,
   parameter int PULSE_MAX = `PULSE_MAX_CYCLES
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic supplyLow,
   input wire logic sleep_request_low,
   input wire logic clear_fault_command, // (R16) (R17)
   input wire logic retryMode,
   input wire logic driverEnable,
   input wire logic overcurrent_trip,
   input wire logic shortToGround,
   input wire logic thermal_shutdown,
   output logic fault_indicator_low,
   output logic outputEnable,
   output logic current_sense_output,
   output logic faultLatched,
   output logic porActive,
   output logic awake
);
   initial
   begin
      if (RETRY_WAIT < 1 || FAULT_CLEAR < 1 || OC_CONFIRM < 1 || INIT_TIME < 1 ||
          PULSE_MIN < 1 || PULSE_MAX < PULSE_MIN ||
          RETRY_WAIT >= (1 << `CNT_W) || FAULT_CLEAR >= (1 << `CNT_W))
         $error("wake_handshake_fault_reaction: bad timing parameter");
   end

   state_e state;
   count_t timer;
   count_t ocCount;
   count_t lowCount;
   logic sleepPrev;
   logic resetPulse;
   logic ackEvent;
   logic ocConfirmed;
   logic sleepReq;
   logic enterSleep;
   logic tsdCause;
   logic retryDue;
   logic latchClear;

   function automatic count_t to_count(input int value);
      to_count = count_t'(value);
   endfunction

   // missing pin reads as permanently high on the external-supply variant
   assign sleepReq = (VARIANT == VAR_SPI_EXT) ? 1'b1 : sleep_request_low; // (R18) (R19)
   assign enterSleep = !sleepReq && lowCount > to_count(PULSE_MAX);
   // acknowledge source depends on variant
   assign ackEvent = (VARIANT == VAR_HW) ? resetPulse : clear_fault_command; // (R5) (R6)
   assign ocConfirmed = overcurrent_trip && ocCount >= to_count(OC_CONFIRM - 1); // (R8)
   // retry start: thermal waits for cooling, other faults for the fixed wait
   assign retryDue = retryMode && (tsdCause ? !thermal_shutdown
      : timer >= to_count(RETRY_WAIT - 1)); // (R9) (R10)
   assign latchClear = !retryMode && ackEvent; // (R13)

   // measure low width of sleep request, flag a pulse on the rising edge
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lowCount <= '0;
         sleepPrev <= 1'b1;
         resetPulse <= 1'b0;
      end
      else
      begin
         sleepPrev <= sleepReq;
         // only an awake device takes a pulse, so a wake edge never acknowledges itself
         resetPulse <= sleepReq && !sleepPrev && awake && lowCount >= to_count(PULSE_MIN)
            && lowCount <= to_count(PULSE_MAX); // (R20)
         if (sleepReq)
            lowCount <= '0;
         else if (lowCount <= to_count(PULSE_MAX))
            lowCount <= lowCount + 1'b1;
      end
   end

   // overcurrent confirmation filter, runs only while output driven
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         ocCount <= '0;
      else if (overcurrent_trip && outputEnable && !porActive)
         ocCount <= ocCount + 1'b1;
      else
         ocCount <= '0;
   end

   // power-on reset follows supply undervoltage
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         porActive <= 1'b1;
      else
         porActive <= supplyLow; // (R3) (R4)
   end

   // main sequencer
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= ST_SLEEP;
         timer <= '0;
         fault_indicator_low <= 1'b1;
         outputEnable <= 1'b0;
         tsdCause <= 1'b0;
         awake <= 1'b0;
      end
      else if (porActive)
      begin
         // held in reset while supply is low, then acknowledge on recovery
         state <= ST_SLEEP; // (R3)
         timer <= '0;
         fault_indicator_low <= 1'b1;
         outputEnable <= 1'b0;
         tsdCause <= 1'b0;
         awake <= 1'b0;
      end
      else if (enterSleep)
      begin
         state <= ST_SLEEP;
         timer <= '0;
         fault_indicator_low <= 1'b1;
         outputEnable <= 1'b0;
         awake <= 1'b0;
      end
      else
      begin
         unique case (state)
            ST_SLEEP:
               if (sleepReq) // (R1)
               begin
                  state <= ST_INIT_ACK;
                  fault_indicator_low <= 1'b0; // (R2)
                  awake <= 1'b1;
                  timer <= '0;
               end
            ST_INIT_ACK:
               if (ackEvent)
               begin
                  state <= ST_STANDBY;
                  fault_indicator_low <= 1'b1; // (R7)
                  outputEnable <= driverEnable;
               end
            ST_STANDBY:
            begin
               outputEnable <= driverEnable;
               if (thermal_shutdown || ocConfirmed)
               begin
                  state <= ST_FAULT_OFF;
                  outputEnable <= 1'b0; // (R8)
                  fault_indicator_low <= 1'b0;
                  tsdCause <= thermal_shutdown;
                  timer <= '0;
               end
            end
            ST_FAULT_OFF:
               if (!retryMode)
               begin
                  if (ackEvent)
                  begin
                     state <= ST_STANDBY; // (R13)
                     fault_indicator_low <= 1'b1;
                     outputEnable <= driverEnable;
                  end
               end
               else if (retryDue) // (R9) (R10)
               begin
                  state <= ST_RETRY_ON;
                  outputEnable <= driverEnable;
                  timer <= '0;
               end
               else
                  timer <= timer + 1'b1;
            ST_RETRY_ON, ST_CLEARING:
            begin
               outputEnable <= driverEnable;
               if (thermal_shutdown || ocConfirmed)
               begin
                  state <= ST_FAULT_OFF; // (R9) (R14)
                  outputEnable <= 1'b0;
                  tsdCause <= thermal_shutdown;
                  timer <= '0;
               end
               else if (!driverEnable)
               begin
                  state <= ST_STANDBY;
                  fault_indicator_low <= 1'b1;
               end
               else if (timer >= to_count(FAULT_CLEAR - 1))
               begin
                  state <= ST_STANDBY;
                  fault_indicator_low <= 1'b1; // (R11)
               end
               else
               begin
                  state <= ST_CLEARING;
                  timer <= timer + 1'b1;
               end
            end
         endcase
      end
   end

   // latched fault status for SPI variants; set wins over clear
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         faultLatched <= 1'b0;
      else if (VARIANT == VAR_HW)
         faultLatched <= 1'b0;
      else if (ocConfirmed || (thermal_shutdown && awake))
         faultLatched <= 1'b1; // (R12)
      else if (clear_fault_command)
         faultLatched <= 1'b0;
   end

   // short-to-ground indication while disabled by high-side overcurrent
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         current_sense_output <= 1'b0;
      else
         current_sense_output <= state == ST_FAULT_OFF && !tsdCause && shortToGround
            && !porActive && !enterSleep
            && !retryDue && !latchClear; // (R15)
   end

   a_wake_ack_low: assert property (@(posedge clk) disable iff (!resetn)
      state == ST_SLEEP && sleepReq && !porActive && !enterSleep
      |=> !fault_indicator_low && state == ST_INIT_ACK) // (R2)
      else $error("wake acknowledge missing");
   a_ack_release: assert property (@(posedge clk) disable iff (!resetn)
      state == ST_INIT_ACK && ackEvent && !porActive && !enterSleep
      |=> fault_indicator_low && state == ST_STANDBY) // (R7)
      else $error("acknowledge did not release indicator");
   a_oc_disable: assert property (@(posedge clk) disable iff (!resetn)
      state == ST_STANDBY && ocConfirmed && !porActive && !enterSleep
      |=> !outputEnable ##0 !fault_indicator_low) // (R8)
      else $error("overcurrent did not disable output");
   a_retry_low: assert property (@(posedge clk) disable iff (!resetn)
      state == ST_FAULT_OFF && retryMode && !porActive && !enterSleep
      |=> !fault_indicator_low) // (R9)
      else $error("indicator released during retry");
   a_latch_off: assert property (@(posedge clk) disable iff (!resetn)
      state == ST_FAULT_OFF && !retryMode && !ackEvent && !porActive
      |=> !outputEnable) // (R13)
      else $error("output enabled in latch without clear");
   a_retry_on: assert property (@(posedge clk) disable iff (!resetn)
      state == ST_FAULT_OFF && retryDue && !porActive && !enterSleep
      |=> state == ST_RETRY_ON) // (R9)
      else $error("retry did not start");
   a_por_hold: assert property (@(posedge clk) disable iff (!resetn)
      $rose(porActive) |=> state == ST_SLEEP && !outputEnable) // (R3)
      else $error("reset did not hold sequencer");
   a_status_held: assert property (@(posedge clk) disable iff (!resetn)
      faultLatched && !clear_fault_command |=> faultLatched) // (R12)
      else $error("fault status dropped without clear");
   a_short_flag: assert property (@(posedge clk) disable iff (!resetn)
      current_sense_output |-> !outputEnable) // (R15)
      else $error("short indication while output enabled");
   a_pulse_width: assert property (@(posedge clk) disable iff (!resetn)
      resetPulse |-> $past(lowCount) >= to_count(PULSE_MIN)) // (R20)
      else $error("reset pulse too short");
   c_wake: cover property (@(posedge clk) disable iff (!resetn)
      state == ST_INIT_ACK ##[1:100] state == ST_STANDBY);
   c_retry: cover property (@(posedge clk) disable iff (!resetn)
      state == ST_FAULT_OFF ##1 state == ST_RETRY_ON);
   c_clear: cover property (@(posedge clk) disable iff (!resetn)
      state == ST_CLEARING ##1 state == ST_STANDBY);
   c_pulse: cover property (@(posedge clk) disable iff (!resetn) resetPulse);
   c_latch: cover property (@(posedge clk) disable iff (!resetn)
      state == ST_FAULT_OFF && latchClear);
endmodule

/* File: test/host_ctrl_model.sv */
`timescale 1ns/100ps
// controller model: drives the sleep request and the decoded clear command
module host_ctrl_model
(
   input wire logic clk,
   output logic sleep_request_low,
   output logic clear_fault_command
);
   // idle: asleep, no command pending
   initial
   begin
      sleep_request_low = 1'b0;
      clear_fault_command = 1'b0;
   end
   // raise the sleep request input to start a wake-up
   task automatic wake();
      @(posedge clk);
      #2 sleep_request_low = 1'b1;
   endtask
   // one-cycle clear command after a chosen lag, sent whatever the indicator level
   task automatic clearFault(input int lag);
      repeat (lag) @(posedge clk);
      #2 clear_fault_command = 1'b1;
      @(posedge clk);
      #2 clear_fault_command = 1'b0;
   endtask
   // brief low on the sleep request input, width in cycles
   task automatic sleepPulse(input int width);
      @(posedge clk);
      #2 sleep_request_low = 1'b0;
      repeat (width) @(posedge clk);
      #2 sleep_request_low = 1'b1;
   endtask
endmodule

/* File: test/wake_handshake_fault_reaction_tb_top.sv */
`timescale 1ns/100ps
module wake_handshake_fault_reaction_tb_top;
   import wake_fault_pkg::*;
   localparam int RW = 20;
   localparam int FC = 20;
   localparam int OC = 4;
   logic clk, resetn, supplyLow, sleep_request_low, clear_fault_command, retryMode;
   logic driverEnable, overcurrent_trip, shortToGround, thermal_shutdown;
   logic fault_indicator_low, outputEnable, current_sense_output, faultLatched;
   logic porActive, awake;
   logic hwSleepRequestLow, hwClear, hwFaultLow, hwLatched, hwAwake;
   int nMismatch = 0;
   int testsRun = 0;
   // shortened counts keep the run brief
   wake_handshake_fault_reaction #(.VARIANT(VAR_SPI_INT), .RETRY_WAIT(RW),
      .FAULT_CLEAR(FC), .OC_CONFIRM(OC))
      wake_handshake_fault_reaction_i (.clk(clk), .resetn(resetn), .supplyLow(supplyLow),
      .sleep_request_low(sleep_request_low), .clear_fault_command(clear_fault_command),
      .retryMode(retryMode), .driverEnable(driverEnable),
      .overcurrent_trip(overcurrent_trip), .shortToGround(shortToGround),
      .thermal_shutdown(thermal_shutdown), .fault_indicator_low(fault_indicator_low),
      .outputEnable(outputEnable), .current_sense_output(current_sense_output),
      .faultLatched(faultLatched), .porActive(porActive), .awake(awake));
   host_ctrl_model host_ctrl_model_i (.clk(clk), .sleep_request_low(sleep_request_low),
      .clear_fault_command(clear_fault_command));
   // hardwired variant: acknowledged by a reset pulse on its own sleep input
   wake_handshake_fault_reaction #(.VARIANT(VAR_HW))
      wake_handshake_fault_reaction_hw_i (.clk(clk), .resetn(resetn), .supplyLow(supplyLow),
      .sleep_request_low(hwSleepRequestLow), .clear_fault_command(hwClear),
      .retryMode(retryMode), .driverEnable(driverEnable),
      .overcurrent_trip(overcurrent_trip), .shortToGround(shortToGround),
      .thermal_shutdown(thermal_shutdown), .fault_indicator_low(hwFaultLow),
      .outputEnable(), .current_sense_output(), .faultLatched(hwLatched),
      .porActive(), .awake(hwAwake));
   host_ctrl_model host_ctrl_model_hw_i (.clk(clk), .sleep_request_low(hwSleepRequestLow),
      .clear_fault_command(hwClear));
   // free-running system clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // verdict and end of run
   task automatic summarize();
      if (nMismatch == 0 && testsRun > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // compare one observed value against its expectation
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         nMismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // pick an output by index: indicator, enable, latched status
   function automatic logic pick(input int which);
      case (which)
         0: return fault_indicator_low;
         1: return outputEnable;
         default: return faultLatched;
      endcase
   endfunction
   // bounded wait for an output to reach a level
   task automatic waitLvl(input int which, input logic lvl, input int bound);
      for (int i = 0; i < bound; i++)
      begin
         @(posedge clk);
         #2;
         if (pick(which) === lvl)
            return;
      end
      check({7'h00, pick(which)}, {7'h00, lvl});
      summarize();
   endtask
   // advance n cycles, landing just after the edge
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   initial
   begin
      resetn = 1'b0;
      supplyLow = 1'b0;
      retryMode = 1'b1;
      driverEnable = 1'b1;
      overcurrent_trip = 1'b0;
      shortToGround = 1'b0;
      thermal_shutdown = 1'b0;
      cycles(20);
      resetn = 1'b1;
      // asleep, then supply undervoltage holds the power-on reset
      cycles(5);
      check(awake, 1'b0);
      supplyLow = 1'b1;
      cycles(5);
      check(porActive, 1'b1);
      check(fault_indicator_low, 1'b1);
      supplyLow = 1'b0;
      cycles(3);
      check(porActive, 1'b0);
      // hardwired wake: too short a pulse is refused, a proper one acknowledges
      host_ctrl_model_hw_i.wake();
      cycles(2);
      check(hwFaultLow, 1'b0);
      check(hwAwake, 1'b1);
      host_ctrl_model_hw_i.sleepPulse(5);
      cycles(3);
      check(hwFaultLow, 1'b0);
      host_ctrl_model_hw_i.sleepPulse(50);
      cycles(1);
      check(hwFaultLow, 1'b0);
      cycles(2);
      check(hwFaultLow, 1'b1);
      check(hwLatched, 1'b0);
      // wake handshake: indicator low, then clear command releases it
      host_ctrl_model_i.wake();
      waitLvl(0, 1'b0, 10);
      check(awake, 1'b1);
      host_ctrl_model_i.clearFault(5);
      waitLvl(0, 1'b1, 5);
      waitLvl(1, 1'b1, 5);
      // retry: short to ground trips, retries, recovers
      overcurrent_trip = 1'b1;
      shortToGround = 1'b1;
      waitLvl(1, 1'b0, OC + 3);
      check(fault_indicator_low, 1'b0);
      cycles(RW / 2);
      check(current_sense_output, 1'b1);
      check(outputEnable, 1'b0);
      waitLvl(1, 1'b1, RW + 5);
      check(fault_indicator_low, 1'b0);
      waitLvl(1, 1'b0, OC + 3);
      overcurrent_trip = 1'b0;
      shortToGround = 1'b0;
      waitLvl(1, 1'b1, RW + 5);
      check(fault_indicator_low, 1'b0);
      waitLvl(0, 1'b1, FC + 5);
      check(outputEnable, 1'b1);
      check(faultLatched, 1'b1);
      host_ctrl_model_i.clearFault(2);
      waitLvl(2, 1'b0, 5);
      // thermal retry waits for cooling, not the fixed wait
      thermal_shutdown = 1'b1;
      waitLvl(1, 1'b0, 10);
      cycles(RW + 10);
      check(outputEnable, 1'b0);
      thermal_shutdown = 1'b0;
      waitLvl(1, 1'b1, 10);
      waitLvl(0, 1'b1, FC + 5);
      host_ctrl_model_i.clearFault(2);
      // latch: stays off, clear re-enables, persisting fault trips again
      retryMode = 1'b0;
      overcurrent_trip = 1'b1;
      waitLvl(1, 1'b0, OC + 3);
      cycles(RW + 10);
      check(outputEnable, 1'b0);
      check(fault_indicator_low, 1'b0);
      host_ctrl_model_i.clearFault(1);
      waitLvl(1, 1'b1, 5);
      waitLvl(1, 1'b0, OC + 5);
      check(fault_indicator_low, 1'b0);
      overcurrent_trip = 1'b0;
      host_ctrl_model_i.clearFault(3);
      waitLvl(0, 1'b1, 5);
      waitLvl(1, 1'b1, 5);
      cycles(OC + 5);
      check(outputEnable, 1'b1);
      // retry cut short: driver disabled during the wait releases the indicator
      retryMode = 1'b1;
      overcurrent_trip = 1'b1;
      waitLvl(1, 1'b0, OC + 3);
      driverEnable = 1'b0;
      overcurrent_trip = 1'b0;
      waitLvl(0, 1'b1, RW + 5);
      check(outputEnable, 1'b0);
      summarize();
   end
endmodule
